// ---- common/csc_stream_pkg.sv ----
package csc_stream_pkg;
   // ****************************************
   // Widths and timing
   // ****************************************
   localparam int COMP_W = 8;
   localparam int DATA_W = 3 * COMP_W;
   localparam int FIFO_DEPTH = 8;
   localparam int BASE_LATENCY = 9;
   localparam int CLIP_EXTRA = 1;
   localparam int CLAMP_EXTRA = 1;
   localparam int PIPE_LATENCY = BASE_LATENCY + CLIP_EXTRA + CLAMP_EXTRA;
   localparam int CLK_PERIOD_NS = 20;
   localparam logic [0:0] SOF_BIT = 1'h0;
   localparam logic [0:0] RST_ACTIVE = 1'h0;
endpackage : csc_stream_pkg

// ---- hdl/stream_fifo.sv ----
`timescale 1ns/10ps
// ****************************************
// Small flip-flop FIFO with clock enable gating
// ****************************************
module stream_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic run_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW-1:0] wr_ff;
   logic [AW-1:0] rd_ff;
   logic [AW:0] cnt_ff;
   wire push = run_i & in_valid_i & in_ready_o;
   wire pop = run_i & out_valid_o & out_ready_i;

   assign in_ready_o = (cnt_ff != DEPTH[AW:0]);
   assign out_valid_o = (cnt_ff != '0);
   assign out_data_o = mem_ff[rd_ff];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wr_ff <= '0;
         rd_ff <= '0;
         cnt_ff <= '0;
      end else begin
         if (push) begin
            mem_ff[wr_ff] <= in_data_i;
            wr_ff <= (wr_ff == AW'(DEPTH - 1)) ? '0 : wr_ff + 1'b1;
         end
         if (pop) begin
            rd_ff <= (rd_ff == AW'(DEPTH - 1)) ? '0 : rd_ff + 1'b1;
         end
         cnt_ff <= cnt_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      end
   end
endmodule : stream_fifo

// ---- hdl/video_stream_port_control.sv ----
`timescale 1ns/10ps
module video_stream_port_control
   import csc_stream_pkg::*;
(
   // Clock, enable, reset
   input wire logic CLK_SYS_I,
   input wire logic CLK_EN_I,
   input wire logic RESET_N_I,
   // Input stream
   input wire logic [DATA_W-1:0] S_TDATA_I,
   input wire logic S_TVALID_I,
   output logic S_TREADY_O,
   input wire logic [0:0] S_TUSER_I,
   input wire logic S_TLAST_I,
   // Output stream
   output logic [DATA_W-1:0] M_TDATA_O,
   output logic M_TVALID_O,
   input wire logic M_TREADY_I,
   output logic [0:0] M_TUSER_O,
   output logic M_TLAST_O
);
   // ****************************************
   // Common control
   // ****************************************
   localparam int BEAT_W = DATA_W + 2;
   // Interrupt outputs are left out: no register port is configured
   // Reset wins over enable, so it is decoded separately
   wire rst = (RESET_N_I == RST_ACTIVE[0]);
   // Every register below uses CLK_SYS_I and CLK_EN_I; all but beat_ff and the FIFO's mem_ff also use rst
   wire run = CLK_EN_I;

   // ****************************************
   // Processing pipeline
   // ****************************************
   // Pipeline advances whenever CLK_EN_I is high; input is only taken while
   // credits remain, so the FIFO has room; 8 credits for 11 stages stall a steady stream.
   logic [PIPE_LATENCY-1:0] vld_ff;
   logic [BEAT_W-1:0] beat_ff [PIPE_LATENCY];
   logic [$clog2(FIFO_DEPTH+PIPE_LATENCY+1)-1:0] credit_ff;
   logic [$clog2(FIFO_DEPTH+PIPE_LATENCY+1)-1:0] nxt_credit;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic [BEAT_W-1:0] fifo_out_data;
   // Credits bound the beats inside pipe plus FIFO to the FIFO depth
   // Nothing is taken while valid is low, so an early start of frame waits
   // Only offered beats enter, so blanking never reaches the output
   wire in_take = run & S_TVALID_I & S_TREADY_O;
   wire out_take = run & M_TVALID_O & M_TREADY_I;
   assign S_TREADY_O = (credit_ff != '0);
   // Pixel, start of frame and line end stay bundled
   wire [BEAT_W-1:0] in_beat = {S_TUSER_I[SOF_BIT], S_TLAST_I, S_TDATA_I};

   always_comb begin
      nxt_credit = credit_ff;
      if (in_take && !out_take) begin
         nxt_credit = credit_ff - 1'b1;
      end else if (out_take && !in_take) begin
         nxt_credit = credit_ff + 1'b1;
      end
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (rst) begin
         credit_ff <= ($bits(credit_ff))'(FIFO_DEPTH);
      end else if (run) begin
         credit_ff <= nxt_credit;
      end
   end

   // Fixed-depth delay line standing in for the conversion arithmetic
   always_ff @(posedge CLK_SYS_I) begin
      if (rst) begin
         vld_ff <= '0;
      end else if (run) begin
         vld_ff <= {vld_ff[PIPE_LATENCY-2:0], in_take};
      end
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (run) begin
         beat_ff[0] <= in_beat;
         for (int i = 1; i < PIPE_LATENCY; i++) begin
            beat_ff[i] <= beat_ff[i-1];
         end
      end
   end

   // ****************************************
   // Output buffer
   // ****************************************
   stream_fifo #(
      .WIDTH(BEAT_W),
      .DEPTH(FIFO_DEPTH)
   ) u_out_fifo (
      .clk_i(CLK_SYS_I),
      .rst_i(rst),
      .run_i(run),
      .in_valid_i(vld_ff[PIPE_LATENCY-1]),
      .in_ready_o(fifo_in_ready),
      .in_data_i(beat_ff[PIPE_LATENCY-1]),
      .out_valid_o(fifo_out_valid),
      .out_ready_i(M_TREADY_I),
      .out_data_o(fifo_out_data)
   );

   // FIFO head is a register, so held until popped
   assign M_TVALID_O = fifo_out_valid;
   assign M_TDATA_O = fifo_out_data[DATA_W-1:0];
   assign M_TLAST_O = fifo_out_data[DATA_W];
   assign M_TUSER_O = fifo_out_data[DATA_W+1 -: 1];

   // ****************************************
   // Checks
   // ****************************************
   a_freeze_out: assert property (@(posedge CLK_SYS_I) disable iff (rst)
      !CLK_EN_I ##1 !rst |-> $stable(M_TVALID_O) && $stable(M_TDATA_O))
      else $error("output moved with enable low");
   a_hold_beat: assert property (@(posedge CLK_SYS_I) disable iff (rst)
      M_TVALID_O && !(M_TREADY_I && CLK_EN_I) |=> M_TVALID_O && $stable(M_TDATA_O)
         && $stable(M_TLAST_O) && $stable(M_TUSER_O))
      else $error("output beat changed before acceptance");
   a_latency_fix: assert property (@(posedge CLK_SYS_I) disable iff (rst)
      in_take && CLK_EN_I [*1] |-> ##11 (vld_ff[PIPE_LATENCY-1] || !CLK_EN_I))
      else $error("pipeline latency wrong");
   a_sof_carry: assert property (@(posedge CLK_SYS_I) disable iff (rst)
      $past(in_take) |-> beat_ff[0][DATA_W+1] == $past(S_TUSER_I[0]))
      else $error("start of frame lost");
   a_no_ovfl: assert property (@(posedge CLK_SYS_I) disable iff (rst)
      vld_ff[PIPE_LATENCY-1] |-> fifo_in_ready)
      else $error("buffer overflow");
   a_reset_clr: assert property (@(posedge CLK_SYS_I)
      rst |=> !M_TVALID_O && S_TREADY_O)
      else $error("reset did not clear");
   a_frozen_in: assert property (@(posedge CLK_SYS_I) disable iff (rst)
      !CLK_EN_I |=> $stable(credit_ff) && $stable(vld_ff))
      else $error("input sampled with enable low");
   a_eol_carry: assert property (@(posedge CLK_SYS_I) disable iff (rst)
      $past(in_take) |-> beat_ff[0][DATA_W] == $past(S_TLAST_I))
      else $error("line end lost");
   c_in_beat: cover property (@(posedge CLK_SYS_I) in_take);
   c_out_beat: cover property (@(posedge CLK_SYS_I) out_take && M_TUSER_O[0]);
   c_full_stall: cover property (@(posedge CLK_SYS_I) !S_TREADY_O);
   c_freeze: cover property (@(posedge CLK_SYS_I) !CLK_EN_I && M_TVALID_O);
endmodule : video_stream_port_control

// ---- test/video_sink_model.sv ----
`timescale 1ns/10ps
// ****************************************
// Downstream sink: ready by mode, records taken beats
// ****************************************
module video_sink_model
   import csc_stream_pkg::*;
(
   // Clock, enable, reset
   input wire logic clk_i,
   input wire logic en_i,
   input wire logic rst_n_i,
   // Stream
   input wire logic [1:0] mode_i,
   input wire logic valid_i,
   input wire logic [DATA_W+1:0] beat_i,
   output logic ready_o
);
   logic [DATA_W+1:0] got[$];
   logic tog_ff = 1'b0;
   // Mode 0 ready, 1 every other cycle, 2 stalled; never waits on valid
   assign ready_o = (mode_i == 2'h0) | ((mode_i == 2'h1) & tog_ff);
   always @(posedge clk_i) begin
      tog_ff <= ~tog_ff;
      if (ready_o && valid_i && en_i && rst_n_i) begin
         got.push_back(beat_i);
      end
   end
endmodule : video_sink_model

// ---- test/video_stream_port_control_test.sv ----
`timescale 1ns/10ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin errors++; \
   $display("ERROR %s expected %h seen %h", n, e, g); end end
module video_stream_port_control_test;
   import csc_stream_pkg::*;
   logic clk = 1'b0, en = 1'b1, rst_n = 1'b0, s_valid = 1'b0, s_user = 1'b0, s_last = 1'b0;
   logic [DATA_W-1:0] s_data = 24'h000000;
   logic [1:0] mode = 2'h0;
   logic [DATA_W+1:0] exp_q[$];
   logic [DATA_W+1:0] held;
   logic m_valid, m_user, m_last, s_ready, m_ready;
   logic [DATA_W-1:0] m_data;
   int errors = 0, tests_run = 0, cycles = 0, n;
   video_stream_port_control i_dut (.CLK_SYS_I(clk), .CLK_EN_I(en), .RESET_N_I(rst_n),
      .S_TDATA_I(s_data), .S_TVALID_I(s_valid), .S_TREADY_O(s_ready), .S_TUSER_I(s_user),
      .S_TLAST_I(s_last), .M_TDATA_O(m_data), .M_TVALID_O(m_valid), .M_TREADY_I(m_ready),
      .M_TUSER_O(m_user), .M_TLAST_O(m_last));
   video_sink_model i_sink (.clk_i(clk), .en_i(en), .rst_n_i(rst_n), .mode_i(mode),
      .valid_i(m_valid), .beat_i({m_user, m_last, m_data}), .ready_o(m_ready));
   initial forever #(CLK_PERIOD_NS / 2) clk = ~clk;
   // ****************************************
   // Helpers
   // ****************************************
   task automatic test_done();
      $display("Comparisons %0d, mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : test_done
   // Beat is held until the edge that takes it
   task automatic send(input logic [DATA_W+1:0] b);
      // Components are full 8-bit, so no upper bits need zero fill
      {s_user, s_last, s_data} = b;
      s_valid = 1'b1;
      exp_q.push_back(b);
      while (s_ready !== 1'b1) @(negedge clk);
      @(negedge clk);
   endtask : send
   task automatic drain(input int cnt);
      logic [DATA_W+1:0] e, g;
      for (int k = 0; k < 300 && i_sink.got.size() < cnt; k++) @(negedge clk);
      `CHK("count", cnt, i_sink.got.size())
      while (i_sink.got.size() > 0) begin
         e = exp_q.pop_front();
         g = i_sink.got.pop_front();
         `CHK("beat", e, g)
      end
   endtask : drain
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic test_stream();
      send({2'h2, 24'h0A0B0C});
      s_valid = 1'b0;
      for (n = 0; n < 40 && m_valid !== 1'b1; n++) @(negedge clk);
      `CHK("latency", PIPE_LATENCY, n)
      drain(1);
      for (int i = 0; i < 5; i++) send({i == 0, i == 4, 24'h100000 + i[DATA_W-1:0]});
      s_valid = 1'b0;
      while (m_valid !== 1'b1) @(negedge clk);
      for (n = 0; n < 10 && m_valid === 1'b1; n++) @(negedge clk);
      `CHK("run", 5, n)
      drain(5);
      $display("test_stream done");
   endtask : test_stream
   task automatic test_fill();
      mode = 2'h2;
      for (n = 0; n < 12 && s_ready === 1'b1; n++) send({2'h0, 24'hC00000 + n[DATA_W-1:0]});
      s_valid = 1'b0;
      `CHK("credit", FIFO_DEPTH, n)
      while (m_valid !== 1'b1) @(negedge clk);
      held = {m_user, m_last, m_data};
      repeat (20) @(negedge clk);
      `CHK("held", held, {m_user, m_last, m_data})
      `CHK("m_valid", 1'b1, m_valid)
      mode = 2'h1;
      drain(FIFO_DEPTH);
      mode = 2'h0;
      $display("test_fill done");
   endtask : test_fill
   task automatic test_enable();
      mode = 2'h2;
      send({2'h3, 24'hABCDEF});
      s_valid = 1'b0;
      while (m_valid !== 1'b1) @(negedge clk);
      held = {m_user, m_last, m_data};
      en = 1'b0;
      mode = 2'h0;
      {s_valid, s_data} = {1'b1, 24'h555555};
      repeat (6) @(negedge clk);
      `CHK("frozen", held, {m_user, m_last, m_data})
      `CHK("ignored", 0, i_sink.got.size())
      rst_n = 1'b0;
      @(negedge clk);
      `CHK("rst_valid", 1'b0, m_valid)
      `CHK("rst_ready", 1'b1, s_ready)
      {rst_n, en, s_valid} = 3'h6;
      exp_q.delete();
      $display("test_enable done");
   endtask : test_enable
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         errors++;
         test_done();
      end
   end
   initial begin
      repeat (4) @(negedge clk);
      rst_n = 1'b1;
      `CHK("m_valid0", 1'b0, m_valid)
      test_stream();
      test_fill();
      test_enable();
      test_stream();
      test_done();
   end
endmodule : video_stream_port_control_test
